// [spr_pkg.sv]
// Package for the setpoint, range and mode controller.
// Assumes a 50 MHz clock and a plain register port with 32-bit data.
package spr_pkg;
  // Register byte offsets
  localparam logic [7:0] SPR_VOLT_OFF     = 8'h00;
  localparam logic [7:0] SPR_CURR_OFF     = 8'h04;
  localparam logic [7:0] SPR_VTRIG_OFF    = 8'h08;
  localparam logic [7:0] SPR_CTRIG_OFF    = 8'h0c;
  localparam logic [7:0] SPR_MTRIG_OFF    = 8'h10;
  localparam logic [7:0] SPR_FUNC_OFF     = 8'h14;
  localparam logic [7:0] SPR_VRANG_OFF    = 8'h18;
  localparam logic [7:0] SPR_CRANG_OFF    = 8'h1c;
  localparam logic [7:0] SPR_VAUTO_OFF    = 8'h20;
  localparam logic [7:0] SPR_CAUTO_OFF    = 8'h24;
  localparam logic [7:0] SPR_MODE_OFF     = 8'h28;
  localparam logic [7:0] SPR_CMD_OFF      = 8'h2c;
  localparam logic [7:0] SPR_LIST_OFF     = 8'h30;
  localparam logic [7:0] SPR_STAT_OFF     = 8'h34;
  localparam logic [7:0] SPR_ERR_OFF      = 8'h38;
  localparam logic [7:0] SPR_VMAX_OFF     = 8'h3c;
  localparam logic [7:0] SPR_VMIN_OFF     = 8'h40;
  localparam logic [7:0] SPR_IMAX_OFF     = 8'h44;
  localparam logic [7:0] SPR_IMIN_OFF     = 8'h48;
  // Command register bits
  localparam int SPR_CMD_INIT_BIT = 0;
  localparam int SPR_CMD_TRG_BIT  = 1;
  localparam int SPR_CMD_RST_BIT  = 2;
  localparam int SPR_CMD_OUTP_BIT = 3;
  // Mode register fields
  localparam int SPR_MODE_DUR_LSB = 16;
  // Range answers
  localparam logic [31:0] SPR_RANGE_FULL    = 32'h0000_0001;
  localparam logic [31:0] SPR_RANGE_QUARTER = 32'h0000_0004;
  // Posted error code, two's complement of 222
  localparam logic [31:0] SPR_ERR_RANGE     = 32'hffff_ff22;
  localparam logic [31:0] SPR_ERR_NONE      = 32'h0000_0000;
  // Model limits in converter codes
  localparam logic signed [15:0] SPR_VMAX_DEF = 16'sh7fff;
  localparam logic signed [15:0] SPR_IMAX_DEF = 16'sh7fff;
  localparam logic signed [15:0] SPR_NOMFS_DEF = 16'sh7fff;
  localparam logic signed [15:0] SPR_ZERO     = 16'sh0000;
  // Timing
  localparam int SPR_CLK_HZ        = 50_000_000;
  localparam int SPR_TICK_US       = 1000;
  localparam int SPR_CYC_PER_TICK  = SPR_CLK_HZ / 1_000_000 * SPR_TICK_US;
  localparam int SPR_TRAN_MAX_S    = 10;
  localparam int SPR_TRAN_MAX_MS   = SPR_TRAN_MAX_S * 1000;

  typedef enum logic [1:0] {SPR_MODE_FIX, SPR_MODE_LIST, SPR_MODE_TRAN} spr_mode_t;

  typedef struct packed {
    logic signed [15:0] volt;
    logic signed [15:0] curr;
    logic               curr_mode;
  } spr_set_t;
endpackage

// [spr_ctrl.sv]
// Setpoint, range and operating-mode command interpreter.
// Assumes commands arrive as register writes; list contents live outside.
`timescale 1ns/10ps

// Functional notes
// - Current range read answers 1 for full scale, 4 for quarter scale.
// - Autoranging is on after power-up and after the reset command.
// - Autorange off on enable write of 0 or explicit range 1 or 4.
// - Auto picks full when value exceeds quarter of nominal scale, else quarter.
// - Staged current moves to active setpoint only on executed trigger.
// - Voltage or current beyond model maximum is rejected, error -222 posted.
// - Staged current read returns the last staged current write.
// - Immediate voltage write loads programmed voltage setpoint.
// - Voltage reads give programmed value, model maximum and minimum.
// - Default fixed mode; list-building writes accepted.
// - List mode starts list; list-building writes refused with command error.
// - Fixed mode during list halts it and restores pre-list settings.
// - List finishing normally leaves the last step settings in effect.
// - Armed transient: next voltage write pulses for duration then reverts.
// - Armed transient: trigger pulses staged voltage for duration then reverts.
// - Mode read gives list while running, transient while armed, else fixed.
// - Voltage-range write sets voltage or current range by active mode; 1 or 4.
// - Quarter range spreads full 16-bit code over a quarter of full scale.
// - Reset gives zero volts, zero amps, voltage mode; output held until enabled.
// - Trigger without prior initiate changes nothing.
// - Executed trigger switches operating mode to the staged mode.
// - Current range is kept until an operating-mode select write.
// - Transient duration above 10 seconds is rejected, error -222 posted.
module spr_ctrl #(
  parameter logic signed [15:0] V_MAX        = spr_pkg::SPR_VMAX_DEF,
  parameter logic signed [15:0] I_MAX        = spr_pkg::SPR_IMAX_DEF,
  parameter logic signed [15:0] NOM_FS       = spr_pkg::SPR_NOMFS_DEF,
  parameter int                 CYC_PER_TICK = spr_pkg::SPR_CYC_PER_TICK
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  // External list engine
  input  wire logic              list_step_valid,
  input  wire spr_pkg::spr_set_t list_step,
  input  wire logic              list_done,
  output logic                   list_running,
  output logic                   list_wr_valid,
  output logic      [31:0]       list_wr_data,
  // Converter side
  output logic      [15:0]       dac_volt,
  output logic      [15:0]       dac_curr,
  output logic                   volt_quarter,
  output logic                   curr_quarter,
  output logic                   curr_mode,
  output logic                   output_on
);
  import spr_pkg::*;

  // Refuse limits the range and timer logic cannot serve
  if (CYC_PER_TICK < 2 || V_MAX <= 0 || I_MAX <= 0 || NOM_FS <= 0) begin : g_bad_param
    $error("spr_ctrl: bad parameter");
  end

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [15:0] scale(input logic signed [15:0] v, input logic q);
    scale = q ? 16'(v <<< 2) : 16'(v);
  endfunction

  // State
  spr_set_t          act_q, stg_q, save_q;
  logic              vauto_q, cauto_q;
  logic              vrange4_q, crange4_q;
  logic              run_q, armed_q, init_q, outp_q;
  logic [13:0]       dur_q, tcnt_q;
  logic              pulse_q;
  logic signed [15:0] pulse_v_q;
  logic              cmd_err_q;
  logic [31:0]       err_q;
  logic [31:0]       rdata_q;
  logic [31:0]       tick_cnt_q;
  logic              tick;

  // Decode
  logic wr_volt, wr_curr, wr_vtrig, wr_ctrig, wr_mtrig, wr_func;
  logic wr_vrang, wr_crang, wr_vauto, wr_cauto, wr_mode, wr_cmd, wr_list;
  logic soft_rst, trg_go, rng_ok;
  logic signed [15:0] wval;
  logic [13:0] wdur;
  logic v_bad, c_bad, dur_bad;
  logic v_q4, c_q4;
  spr_mode_t mode_now;

  assign wval     = wdata[15:0];
  assign wdur     = wdata[SPR_MODE_DUR_LSB +: 14];
  assign wr_volt  = wr && addr == SPR_VOLT_OFF;
  assign wr_curr  = wr && addr == SPR_CURR_OFF;
  assign wr_vtrig = wr && addr == SPR_VTRIG_OFF;
  assign wr_ctrig = wr && addr == SPR_CTRIG_OFF;
  assign wr_mtrig = wr && addr == SPR_MTRIG_OFF;
  assign wr_func  = wr && addr == SPR_FUNC_OFF;
  assign wr_vrang = wr && addr == SPR_VRANG_OFF;
  assign wr_crang = wr && addr == SPR_CRANG_OFF;
  assign wr_vauto = wr && addr == SPR_VAUTO_OFF;
  assign wr_cauto = wr && addr == SPR_CAUTO_OFF;
  assign wr_mode  = wr && addr == SPR_MODE_OFF;
  assign wr_cmd   = wr && addr == SPR_CMD_OFF;
  assign wr_list  = wr && addr == SPR_LIST_OFF;
  assign soft_rst = wr_cmd && wdata[SPR_CMD_RST_BIT];
  assign rng_ok   = wdata == SPR_RANGE_FULL || wdata == SPR_RANGE_QUARTER;

  assign trg_go = wr_cmd && wdata[SPR_CMD_TRG_BIT] && init_q;

  // Effective ranges from value or explicit choice
  assign v_q4 = vauto_q ? (mag(act_q.volt) <= 16'(NOM_FS >>> 2)) : vrange4_q;
  assign c_q4 = cauto_q ? (mag(act_q.curr) <= 16'(NOM_FS >>> 2)) : crange4_q;

  // Limit checks, manual quarter current range (autorange off) caps current at a quarter of maximum
  assign v_bad = (wval > V_MAX) || (wval < -V_MAX);
  assign c_bad = (wval > I_MAX) || (wval < -I_MAX) ||
                 (!cauto_q && crange4_q && mag(wval) > 16'(I_MAX >>> 2));
  assign dur_bad = 32'(wdur) > 32'(SPR_TRAN_MAX_MS);

  always_comb begin
    if (run_q) begin
      mode_now = SPR_MODE_LIST;
    end else if (armed_q) begin
      mode_now = SPR_MODE_TRAN;
    end else begin
      mode_now = SPR_MODE_FIX;
    end
  end

  // Millisecond tick for transient timing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick_cnt_q == 32'(CYC_PER_TICK - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end
  assign tick = tick_cnt_q == 32'(CYC_PER_TICK - 1);

  // Programmed setpoints and operating mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_q  <= '0;
      save_q <= '0;
    end else if (soft_rst) begin
      act_q  <= '0;
    end else if (wr_mode && wdata[1:0] == 2'h0 && run_q) begin
      act_q  <= save_q;
    end else if (wr_mode && wdata[1:0] == 2'h1 && !run_q) begin
      save_q <= act_q;
    end else if (run_q && list_step_valid) begin
      act_q  <= list_step;
    end else if (trg_go && !armed_q) begin
      act_q  <= stg_q;
    end else if (trg_go && armed_q) begin
      act_q.curr      <= stg_q.curr;
      act_q.curr_mode <= stg_q.curr_mode;
    end else if (wr_volt && !v_bad && !armed_q) begin
      act_q.volt <= wval;
    end else if (wr_curr && !c_bad) begin
      act_q.curr <= wval;
    end else if (wr_func) begin
      act_q.curr_mode <= wdata[0];
    end
  end

  // Staged values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stg_q <= '0;
    end else if (soft_rst) begin
      stg_q <= '0;
    end else if (trg_go) begin
      stg_q <= stg_q; // Staged set is kept for the next trigger
    end else if (wr_vtrig && !v_bad) begin
      stg_q.volt <= wval;
    end else if (wr_ctrig && !c_bad) begin
      stg_q.curr <= wval;
    end else if (wr_mtrig) begin
      stg_q.curr_mode <= wdata[0];
    end
  end

  // Range selection and autoranging
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vauto_q   <= 1'b1;
      cauto_q   <= 1'b1;
      vrange4_q <= 1'b0;
      crange4_q <= 1'b0;
    end else if (soft_rst) begin
      vauto_q   <= 1'b1;
      cauto_q   <= 1'b1;
      vrange4_q <= 1'b0;
      crange4_q <= 1'b0;
    end else if ((wr_vauto || wr_cauto) && wdata[0] == 1'b0) begin
      vauto_q   <= 1'b0;
      cauto_q   <= 1'b0;
      vrange4_q <= v_q4;
      crange4_q <= c_q4;
    end else if ((wr_vauto || wr_cauto) && wdata[0]) begin
      vauto_q   <= 1'b1;
      cauto_q   <= 1'b1;
    end else if ((wr_vrang || wr_crang) && rng_ok) begin
      vauto_q   <= 1'b0;
      cauto_q   <= 1'b0;
      if (wr_crang || act_q.curr_mode) begin
        crange4_q <= wdata == SPR_RANGE_QUARTER;
        vrange4_q <= v_q4;
      end else begin
        vrange4_q <= wdata == SPR_RANGE_QUARTER;
        crange4_q <= c_q4;
      end
    end else if (wr_func) begin
      crange4_q <= 1'b0;
    end
  end

  // List execution
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (soft_rst) begin
      run_q <= 1'b0;
    end else if (wr_mode && wdata[1:0] == 2'h1) begin
      run_q <= 1'b1;
    end else if (wr_mode && wdata[1:0] == 2'h0) begin
      run_q <= 1'b0;
    end else if (list_done) begin
      run_q <= 1'b0;
    end
  end

  // Transient arming, pulse and timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q   <= 1'b0;
      dur_q     <= 14'h0000;
      pulse_q   <= 1'b0;
      pulse_v_q <= SPR_ZERO;
      tcnt_q    <= 14'h0000;
    end else if (soft_rst) begin
      armed_q   <= 1'b0;
      pulse_q   <= 1'b0;
    end else if (wr_mode && wdata[1:0] == 2'h2 && !dur_bad && !run_q) begin
      armed_q   <= 1'b1;
      dur_q     <= wdur;
    end else if (armed_q && ((wr_volt && !v_bad) || trg_go)) begin
      armed_q   <= 1'b0;
      pulse_q   <= 1'b1;
      pulse_v_q <= trg_go ? stg_q.volt : wval;
      tcnt_q    <= dur_q;
    end else if (wr_mode && wdata[1:0] == 2'h0) begin
      armed_q   <= 1'b0;
    end else if (pulse_q && tick) begin
      if (tcnt_q <= 14'h0001) begin
        pulse_q <= 1'b0; // Reverts to the held setpoint
      end
      tcnt_q <= tcnt_q - 14'h0001;
    end
  end

  // Trigger capability and output enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_q <= 1'b0;
      outp_q <= 1'b0;
    end else if (soft_rst) begin
      init_q <= 1'b0;
      outp_q <= 1'b0;
    end else if (wr_cmd) begin
      // Initiate arms one trigger; set wins over the consuming trigger
      init_q <= wdata[SPR_CMD_INIT_BIT] || (init_q && !wdata[SPR_CMD_TRG_BIT]);
      outp_q <= outp_q || wdata[SPR_CMD_OUTP_BIT];
    end
  end

  // Errors: set wins over read-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q     <= SPR_ERR_NONE;
      cmd_err_q <= 1'b0;
    end else begin
      if ((wr_volt || wr_vtrig) && v_bad ||
          (wr_curr || wr_ctrig) && c_bad ||
          wr_mode && wdata[1:0] == 2'h2 && dur_bad) begin
        err_q <= SPR_ERR_RANGE;
      end else if (rd && addr == SPR_ERR_OFF) begin
        err_q <= SPR_ERR_NONE;
      end
      if (wr_list && run_q) begin
        cmd_err_q <= 1'b1;
      end else if (rd && addr == SPR_STAT_OFF) begin
        cmd_err_q <= 1'b0;
      end
    end
  end

  // List-building writes pass out only while no list runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      list_wr_valid <= 1'b0;
      list_wr_data  <= 32'h0000_0000;
    end else begin
      list_wr_valid <= wr_list && !run_q;
      list_wr_data  <= wr_list ? wdata : list_wr_data;
    end
  end

  // Converter codes; quarter range multiplies the code by four
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_volt     <= 16'h0000;
      dac_curr     <= 16'h0000;
      volt_quarter <= 1'b0;
      curr_quarter <= 1'b0;
    end else if (!outp_q) begin
      dac_volt     <= 16'h0000;
      dac_curr     <= 16'h0000;
      volt_quarter <= v_q4;
      curr_quarter <= c_q4;
    end else begin
      dac_volt     <= scale(pulse_q ? pulse_v_q : act_q.volt, v_q4);
      dac_curr     <= scale(act_q.curr, c_q4);
      volt_quarter <= v_q4;
      curr_quarter <= c_q4;
    end
  end

  // Read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        SPR_VOLT_OFF:  rdata_q <= 32'(act_q.volt);
        SPR_CURR_OFF:  rdata_q <= 32'(act_q.curr);
        SPR_VTRIG_OFF: rdata_q <= 32'(stg_q.volt);
        SPR_CTRIG_OFF: rdata_q <= 32'(stg_q.curr);
        SPR_MTRIG_OFF: rdata_q <= {31'h0, stg_q.curr_mode};
        SPR_FUNC_OFF:  rdata_q <= {31'h0, act_q.curr_mode};
        SPR_VRANG_OFF: rdata_q <= (act_q.curr_mode ? c_q4 : v_q4) ?
                                  SPR_RANGE_QUARTER : SPR_RANGE_FULL;
        SPR_CRANG_OFF: rdata_q <= c_q4 ? SPR_RANGE_QUARTER : SPR_RANGE_FULL;
        SPR_VAUTO_OFF: rdata_q <= {31'h0, vauto_q};
        SPR_CAUTO_OFF: rdata_q <= {31'h0, cauto_q};
        SPR_MODE_OFF:  rdata_q <= {2'h0, dur_q, 14'h0, mode_now};
        SPR_STAT_OFF:  rdata_q <= {25'h0, pulse_q, outp_q, init_q, cmd_err_q,
                                   act_q.curr_mode, mode_now};
        SPR_ERR_OFF:   rdata_q <= err_q;
        SPR_VMAX_OFF:  rdata_q <= 32'(V_MAX);
        SPR_VMIN_OFF:  rdata_q <= 32'(-V_MAX);
        SPR_IMAX_OFF:  rdata_q <= 32'(I_MAX);
        SPR_IMIN_OFF:  rdata_q <= 32'(-I_MAX);
        default:       rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata        = rdata_q;
  assign list_running = run_q;
  assign curr_mode    = act_q.curr_mode;
  assign output_on    = outp_q;
endmodule // spr_ctrl

// [spr_ctrl_properties.sv]
// Port checker for the setpoint, range and mode controller.
// Assumes one clock domain and the register map of spr_pkg.
`timescale 1ns/10ps
module spr_ctrl_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // List engine
  input wire logic        list_done,
  input wire logic        list_running,
  input wire logic        list_wr_valid,
  input wire logic [31:0] list_wr_data,
  // Converter side
  input wire logic [15:0] dac_volt,
  input wire logic [15:0] dac_curr,
  input wire logic        curr_mode,
  input wire logic        output_on
);
  import spr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 32'h0) else $error("read data not zero outside answer");
  list_accept_a: assert property (
    wr && addr == SPR_LIST_OFF && !list_running |=> list_wr_valid && list_wr_data == $past(wdata))
    else $error("list write not accepted");
  list_refuse_a: assert property (
    list_wr_valid |-> $past(wr) && $past(addr) == SPR_LIST_OFF && !$past(list_running))
    else $error("list write accepted while running");
  list_start_a: assert property (
    wr && addr == SPR_MODE_OFF && wdata[1:0] == 2'h1 |=> list_running)
    else $error("list did not start");
  list_halt_a: assert property (
    list_running && wr && addr == SPR_MODE_OFF && wdata[1:0] == 2'h0 |=> !list_running)
    else $error("list did not halt");
  list_end_a: assert property (
    list_running && list_done && !wr |=> !list_running) else $error("list did not end");
  mode_select_a: assert property (
    wr && addr == SPR_FUNC_OFF && !list_running |=> curr_mode == $past(wdata[0]))
    else $error("operating mode not taken");
  dac_off_a: assert property (
    !output_on && !$past(output_on) |-> dac_volt == 16'h0 && dac_curr == 16'h0)
    else $error("converter driven with output off");
  soft_reset_a: assert property (
    wr && addr == SPR_CMD_OFF && wdata[SPR_CMD_RST_BIT] && !wdata[SPR_CMD_OUTP_BIT]
    |=> !output_on && !list_running && !curr_mode) else $error("soft reset defaults wrong");
endmodule // spr_ctrl_properties

bind spr_ctrl spr_ctrl_properties chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .list_done, .list_running, .list_wr_valid, .list_wr_data, .dac_volt, .dac_curr,
  .curr_mode, .output_on);

// [spr_list_model.sv]
// External list engine model: one step per run, optional completion.
// Assumes list_running from the controller and a single clock.
`timescale 1ns/10ps
module spr_list_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Control from bench
  input  wire logic              finish,
  input  wire logic [15:0]       step_v,
  // Controller side
  input  wire logic              list_running,
  output logic                   list_step_valid,
  output spr_pkg::spr_set_t      list_step,
  output logic                   list_done
);
  import spr_pkg::*;
  logic [3:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q           <= 4'h0;
      list_step_valid <= 1'b0;
      list_step       <= '0;
      list_done       <= 1'b0;
    end else begin
      cnt_q           <= !list_running ? 4'h0 : (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
      list_step_valid <= list_running && cnt_q == 4'h2;
      list_done       <= list_running && finish && cnt_q == 4'h6;
      // Off the valid cycle the data inverts every cycle, so a stale value looks good only every other cycle
      list_step <= (list_running && cnt_q == 4'h2) ? {step_v, 16'h0, 1'b0} : ~list_step;
    end
  end
endmodule // spr_list_model

// [spr_ctrl_tb.sv]
// Self-checking bench for the setpoint, range and mode controller.
// Assumes the list model and the bound port checker.
`timescale 1ns/10ps
module spr_ctrl_tb;
  import spr_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, finish = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, list_wr_data, r;
  logic [15:0] dac_volt, dac_curr, v;
  logic        list_step_valid, list_done, list_running, list_wr_valid;
  logic        volt_quarter, curr_quarter, curr_mode, output_on;
  spr_set_t    list_step;
  int          n_fail = 0, check_count = 0, seed = 14, cyc = 0;
  localparam logic [15:0] QFS = 16'h1000;

  always #10 clk = ~clk;

  // Small limits and a short tick keep the run brief
  spr_ctrl #(.V_MAX(16'sh6000), .I_MAX(16'sh6000), .NOM_FS(16'sh4000), .CYC_PER_TICK(10)) uut (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .list_step_valid, .list_step, .list_done,
    .list_running, .list_wr_valid, .list_wr_data, .dac_volt, .dac_curr, .volt_quarter,
    .curr_quarter, .curr_mode, .output_on);
  spr_list_model lm (.clk, .rst, .finish, .step_v(16'h2000), .list_running,
    .list_step_valid, .list_step, .list_done);

  function automatic logic [31:0] exp_rng(input logic [15:0] x);
    return (x > QFS) ? SPR_RANGE_FULL : SPR_RANGE_QUARTER;
  endfunction
  function automatic logic [15:0] exp_dac(input logic [15:0] x);
    return (x > QFS) ? x : {x[13:0], 2'b00};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] g;
    rreg(a, g);
    chk_reg(nm, e, g);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(SPR_VOLT_OFF, 32'h0, "volt");
    rchk(SPR_MODE_OFF, 32'h0, "mode");
    chk_val("curr_mode", 16'h0, {15'h0, curr_mode});
    wreg(SPR_VOLT_OFF, 32'h0400);
    tick(2);
    chk_val("dac held", 16'h0, dac_volt);
    wreg(SPR_CMD_OFF, 32'h8);
    for (int i = 0; i < 10; i++) begin
      v = 16'($random(seed));
      v[15:14] = 2'b00;
      if (i < 2) v = i ? 16'h1001 : 16'h1000;
      wreg(SPR_VOLT_OFF, {16'h0, v});
      tick(2);
      chk_val("dac_volt", exp_dac(v), dac_volt);
      chk_val("volt_quarter", {15'h0, exp_rng(v) == SPR_RANGE_QUARTER}, {15'h0, volt_quarter});
      rchk(SPR_VRANG_OFF, exp_rng(v), "range");
      rchk(SPR_VOLT_OFF, {16'h0, v}, "volt");
    end
    rreg(SPR_VMAX_OFF, r);
    chk_val("vmax", 16'h6000, r[15:0]);
    rreg(SPR_VMIN_OFF, r);
    chk_val("vmin", 16'ha000, r[15:0]);
    wreg(SPR_VOLT_OFF, 32'h6001);
    rchk(SPR_ERR_OFF, SPR_ERR_RANGE, "volt error");
    rchk(SPR_ERR_OFF, SPR_ERR_NONE, "error cleared");
    rchk(SPR_VOLT_OFF, {16'h0, v}, "volt kept");
    wreg(SPR_CURR_OFF, 32'h6001);
    rchk(SPR_ERR_OFF, SPR_ERR_RANGE, "curr error");
    $display("test limits and ranging done");
    wreg(SPR_CURR_OFF, 32'h0100);
    rchk(SPR_CRANG_OFF, SPR_RANGE_QUARTER, "auto curr range");
    wreg(SPR_CRANG_OFF, 32'h1);
    wreg(SPR_CURR_OFF, 32'h0080);
    tick(2);
    chk_val("dac_curr full", 16'h0080, dac_curr);
    chk_val("curr_quarter full", 16'h0, {15'h0, curr_quarter});
    rchk(SPR_CRANG_OFF, SPR_RANGE_FULL, "manual range");
    wreg(SPR_CAUTO_OFF, 32'h1);
    wreg(SPR_CURR_OFF, 32'h0080);
    tick(2);
    chk_val("dac_curr auto", 16'h0200, dac_curr);
    wreg(SPR_VAUTO_OFF, 32'h0);
    wreg(SPR_CURR_OFF, 32'h1400);
    tick(2);
    chk_val("dac_curr frozen", 16'h5000, dac_curr);
    chk_val("curr_quarter frozen", 16'h1, {15'h0, curr_quarter});
    wreg(SPR_CTRIG_OFF, 32'h0200);
    rchk(SPR_CTRIG_OFF, 32'h0200, "staged curr");
    wreg(SPR_VTRIG_OFF, 32'h0300);
    wreg(SPR_MTRIG_OFF, 32'h1);
    wreg(SPR_CMD_OFF, 32'h2);
    rchk(SPR_CURR_OFF, 32'h1400, "no trigger");
    chk_val("curr_mode", 16'h0, {15'h0, curr_mode});
    wreg(SPR_CMD_OFF, 32'h1);
    wreg(SPR_CMD_OFF, 32'h2);
    rchk(SPR_CURR_OFF, 32'h0200, "trig curr");
    rchk(SPR_VOLT_OFF, 32'h0300, "trig volt");
    chk_val("curr_mode", 16'h1, {15'h0, curr_mode});
    wreg(SPR_VRANG_OFF, 32'h4);
    rchk(SPR_CRANG_OFF, SPR_RANGE_QUARTER, "range by mode");
    wreg(SPR_FUNC_OFF, 32'h0);
    rchk(SPR_CRANG_OFF, SPR_RANGE_FULL, "range after mode select");
    $display("test trigger and range done");
    wreg(SPR_CMD_OFF, 32'h4);
    tick(2);
    chk_val("dac after soft reset", 16'h0, dac_volt);
    wreg(SPR_CURR_OFF, 32'h0100);
    rchk(SPR_CRANG_OFF, SPR_RANGE_QUARTER, "auto after soft reset");
    wreg(SPR_CMD_OFF, 32'h8);
    wreg(SPR_VOLT_OFF, 32'h0400);
    wreg(SPR_MODE_OFF, 32'h0002_0002);
    rchk(SPR_MODE_OFF, 32'h0002_0002, "armed");
    wreg(SPR_VOLT_OFF, 32'h0800);
    tick(2);
    chk_val("pulse", 16'h2000, dac_volt);
    tick(40);
    chk_val("revert", 16'h1000, dac_volt);
    rchk(SPR_VOLT_OFF, 32'h0400, "volt kept");
    rreg(SPR_MODE_OFF, r);
    chk_val("mode fixed", 16'h0, {14'h0, r[1:0]});
    wreg(SPR_VTRIG_OFF, 32'h0c00);
    wreg(SPR_CMD_OFF, 32'h1);
    wreg(SPR_MODE_OFF, 32'h0002_0002);
    wreg(SPR_CMD_OFF, 32'h2);
    tick(2);
    chk_val("trig pulse", 16'h3000, dac_volt);
    tick(40);
    chk_val("trig revert", 16'h1000, dac_volt);
    wreg(SPR_MODE_OFF, {16'd10001, 16'h2});
    rchk(SPR_ERR_OFF, SPR_ERR_RANGE, "long transient");
    rreg(SPR_MODE_OFF, r);
    chk_val("not armed", 16'h0, {14'h0, r[1:0]});
    wreg(SPR_MODE_OFF, {16'd10000, 16'h2});
    rreg(SPR_MODE_OFF, r);
    chk_val("armed at limit", 16'h2, {14'h0, r[1:0]});
    wreg(SPR_CMD_OFF, 32'h4);
    $display("test transient done");
    wreg(SPR_CMD_OFF, 32'h8);
    wreg(SPR_VOLT_OFF, 32'h0400);
    wreg(SPR_LIST_OFF, 32'h5);
    #1;
    chk_val("list write", 16'h1, {15'h0, list_wr_valid});
    wreg(SPR_MODE_OFF, 32'h1);
    wreg(SPR_LIST_OFF, 32'h6);
    rreg(SPR_STAT_OFF, r);
    chk_val("command error", 16'h1, {15'h0, r[3]});
    tick(12);
    chk_val("list step", 16'h2000, dac_volt);
    wreg(SPR_MODE_OFF, 32'h0);
    tick(2);
    chk_val("restored", 16'h1000, dac_volt);
    rchk(SPR_VOLT_OFF, 32'h0400, "restored volt");
    finish <= 1'b1;
    wreg(SPR_MODE_OFF, 32'h1);
    tick(12);
    chk_val("list ended", 16'h0, {15'h0, list_running});
    chk_val("last step kept", 16'h2000, dac_volt);
    rreg(SPR_MODE_OFF, r);
    chk_val("mode after list", 16'h0, {14'h0, r[1:0]});
    $display("test list done");
    final_report();
  end
endmodule // spr_ctrl_tb
